// *** rtl/pic_pkg.sv ***
// Shared constants for the peripheral interrupt controller and its core-side partner
package pic_pkg;
  localparam int unsigned PERIPH_COUNT   = 11;
  localparam int unsigned CORE_COUNT     = 8;
  localparam int unsigned VEC_W          = 16;
  localparam int unsigned IDX_W          = 4;
  // Vector table layout: slots are four words apart
  localparam logic [15:0] TABLE_FIRST    = 16'h0000;
  localparam logic [15:0] TABLE_LAST     = 16'h005F;
  localparam logic [15:0] PERIPH_VEC_LO  = 16'h0030;
  localparam logic [15:0] PERIPH_VEC_HI  = 16'h0058;
  localparam logic [15:0] SLOT_STRIDE    = 16'h0004;
  // Core interrupt indices in priority order, highest first
  localparam int unsigned CI_PERIPH      = 0;
  localparam int unsigned CI_SPORT0_TX   = 1;
  localparam int unsigned CI_SPORT0_RX   = 2;
  localparam int unsigned CI_SOFT1       = 3;
  localparam int unsigned CI_SOFT0       = 4;
  localparam int unsigned CI_REQ_ONE     = 5;
  localparam int unsigned CI_REQ_ZERO    = 6;
  localparam int unsigned CI_TIMER       = 7;
  localparam logic [15:0] VEC_PERIPH     = 16'h0004;
  localparam logic [15:0] VEC_SPORT0_TX  = 16'h0010;
  // Mask bit of the shared peripheral request inside the core mask register cmask
  localparam int unsigned MASK_PERIPH_BIT = 9;
  localparam int unsigned CORE_MASK_W    = 10;
  localparam int unsigned FC_FORCE_LSB   = 8;
  // Sensitivity control fields
  localparam int unsigned SENS_ZERO_BIT  = 0;
  localparam int unsigned SENS_ONE_BIT   = 1;
  localparam int unsigned SENS_PERIPH_BIT = 2;
  localparam int unsigned SENS_NEST_BIT  = 4;
  localparam int unsigned SENS_W         = 5;
  // AXI4-Lite register map of the core-side controller
  localparam logic [7:0] OFF_CORE_MASK   = 8'h00;
  localparam logic [7:0] OFF_FORCE_CLEAR = 8'h04;
  localparam logic [7:0] OFF_SENS        = 8'h08;
  localparam logic [7:0] OFF_PERIPH_MASK = 8'h0C;
  localparam logic [7:0] OFF_PENDING     = 8'h10;
  localparam logic [7:0] OFF_VECTOR      = 8'h14;
  localparam logic [7:0] OFF_STATUS      = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h1C;
  localparam logic [7:0] OFF_SERVICE     = 8'h20;
  localparam logic [7:0] OFF_DONE        = 8'h24;
  localparam logic [1:0] RESP_OKAY       = 2'b00;
  localparam logic [1:0] RESP_SLVERR     = 2'b10;
  localparam logic [VEC_W-1:0] RESET_VEC = 16'h0000;
  localparam int unsigned STATUS_W       = 2;
  localparam int unsigned EV_TAKEN       = 0;
  localparam int unsigned EV_VECTOR      = 1;
endpackage : pic_pkg

// *** rtl/pic_link_if.sv ***
// Link between the peripheral interrupt controller and the core interrupt logic
`timescale 1ns/1ps
interface pic_link_if;
  import pic_pkg::*;
  logic             peripheral_request_line;
  logic [VEC_W-1:0] vector_value;
  logic             vector_read;
  logic [PERIPH_COUNT-1:0] peripheral_interrupt_mask;
  logic             mask_write;
  logic [PERIPH_COUNT-1:0] mask_value;

  modport pic (
    output peripheral_request_line,
    output vector_value,
    output peripheral_interrupt_mask,
    input  vector_read,
    input  mask_write,
    input  mask_value
  );
  modport core (
    input  peripheral_request_line,
    input  vector_value,
    input  peripheral_interrupt_mask,
    output vector_read,
    output mask_write,
    output mask_value
  );
endinterface : pic_link_if

// *** rtl/peripheral_interrupt_controller.sv ***
// Peripheral interrupt controller: prioritises eleven events onto one request line
`timescale 1ns/1ps
module peripheral_interrupt_controller
  import pic_pkg::*;
(
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_i,
  input  wire logic [PERIPH_COUNT-1:0] periph_event_i,
  output logic      [PERIPH_COUNT-1:0] pending_o,
  pic_link_if.pic                      link
);
  logic [PERIPH_COUNT-1:0] pending;
  logic [PERIPH_COUNT-1:0] next_pending;
  logic [PERIPH_COUNT-1:0] pmask;
  logic [PERIPH_COUNT-1:0] next_pmask;
  logic [VEC_W-1:0]        vector;
  logic [VEC_W-1:0]        next_vector;
  logic                    loaded;
  logic                    next_loaded;
  logic [IDX_W-1:0]        loaded_idx;
  logic [IDX_W-1:0]        next_loaded_idx;
  logic [PERIPH_COUNT-1:0] active;
  logic                    any_active;
  logic [IDX_W-1:0]        top_idx;

  // Slot address of source i; index 0 is highest priority
  function automatic logic [VEC_W-1:0] slot_addr(input logic [IDX_W-1:0] idx);
    slot_addr = PERIPH_VEC_LO + VEC_W'({idx, 2'b00});
  endfunction : slot_addr

  always_comb begin
    active     = pending & pmask;
    any_active = |active;
    top_idx    = '0;
    for (int i = PERIPH_COUNT - 1; i >= 0; i--) begin
      if (active[i]) begin
        top_idx = IDX_W'(i);
      end
    end
  end

  always_comb begin
    next_pmask      = link.mask_write ? link.mask_value : pmask;
    next_pending    = pending;
    next_vector     = vector;
    next_loaded     = loaded;
    next_loaded_idx = loaded_idx;
    if (loaded && link.vector_read) begin
      next_pending[loaded_idx] = 1'b0;
      next_loaded              = 1'b0;
    end
    // New events win over the read clear
    next_pending = next_pending | periph_event_i;
    if (!loaded && any_active) begin
      next_vector     = slot_addr(top_idx);
      next_loaded_idx = top_idx;
      next_loaded     = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pending    <= '0;
      pmask      <= '0;
      vector     <= RESET_VEC;
      loaded     <= 1'b0;
      loaded_idx <= '0;
    end else begin
      pending    <= next_pending;
      pmask      <= next_pmask;
      vector     <= next_vector;
      loaded     <= next_loaded;
      loaded_idx <= next_loaded_idx;
    end
  end

  // Request held until the vector has been read
  assign link.peripheral_request_line   = loaded;
  assign link.vector_value              = vector;
  assign link.peripheral_interrupt_mask = pmask;
  assign pending_o                      = pending;
endmodule : peripheral_interrupt_controller

// *** rtl/core_interrupt_logic.sv ***
// Core-side interrupt logic with AXI4-Lite registers: masks, force/clear, nesting, vectors
// What this block and its software do
// - Peripheral needs core bit 9 and its mask
// - Each source enabled only while mask bit set
// - Low bits clear pending, high bits force
// - Software interrupts only via force bits
// - Sensitivity bits choose edge or level
// - Software keeps peripheral line level sensitive
// - Bit 4 allows nesting, else no preemption
// - Vector table spans 0x0000 to 0x005F
// - Core interrupts vector straight to slot
// - Peripheral interrupts vector to 0x0004
// - Vector register holds source slot address
// - Highest priority pending source is presented
// - Vector register holds until core reads
// - New request only after vector read
// - Handler at 0x0004 reads vector, branches
// - Default slot code restores index, returns
// - Priority follows vector address order
// - Eleven peripheral sources share one line
`timescale 1ns/1ps
module core_interrupt_logic
  import pic_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        sport0_tx_i,
  input  wire logic        sport0_rx_i,
  input  wire logic        sport1_tx_req_one_i,
  input  wire logic        sport1_rx_req_zero_i,
  input  wire logic        timer_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq_o,
  pic_link_if.core         link
);
  logic [CORE_MASK_W-1:0] cmask, next_cmask;
  logic [SENS_W-1:0]      sens, next_sens;
  logic [CORE_COUNT-1:0]  pend, next_pend;
  logic [CORE_COUNT-1:0]  line_d, next_line_d;
  logic [15:0]            vec, next_vec;
  logic                   busy, next_busy;
  logic [STATUS_W-1:0]    stat, next_stat;
  logic [STATUS_W-1:0]    core_interrupt_mask, next_core_interrupt_mask;
  logic                   aw_got, next_aw_got, w_got, next_w_got;
  logic [7:0]             aw_a, next_aw_a;
  logic [31:0]            w_d, next_w_d;
  logic                   bv, next_bv, rv, next_rv;
  logic [1:0]             br, next_br, rr, next_rr;
  logic [31:0]            rd, next_rd;
  logic [CORE_COUNT-1:0]  lines, trig, fc_clear, fc_force, enab, cand;
  logic                   wr_go, rd_go, vec_rd, taken;
  logic [2:0]             sel;
  logic [CORE_COUNT-1:0]  cand_masked;

  // Core slot address in priority order
  function automatic logic [15:0] core_slot(input logic [2:0] idx);
    if (idx == 3'(CI_PERIPH)) begin
      core_slot = VEC_PERIPH;
    end else begin
      core_slot = VEC_SPORT0_TX + SLOT_STRIDE * 16'(idx - 3'd1);
    end
  endfunction : core_slot

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
    wr_hit = (a == off);
  endfunction : wr_hit

  always_comb begin
    lines = '0;
    lines[CI_PERIPH]    = link.peripheral_request_line;
    lines[CI_SPORT0_TX] = sport0_tx_i;
    lines[CI_SPORT0_RX] = sport0_rx_i;
    lines[CI_REQ_ONE]   = sport1_tx_req_one_i;
    lines[CI_REQ_ZERO]  = sport1_rx_req_zero_i;
    lines[CI_TIMER]     = timer_i;
    // Edge mode catches rising edges; level mode follows the line
    trig = lines;
    if (sens[SENS_ZERO_BIT]) trig[CI_REQ_ZERO] = lines[CI_REQ_ZERO] & ~line_d[CI_REQ_ZERO];
    if (sens[SENS_ONE_BIT]) trig[CI_REQ_ONE] = lines[CI_REQ_ONE] & ~line_d[CI_REQ_ONE];
    if (sens[SENS_PERIPH_BIT]) trig[CI_PERIPH] = lines[CI_PERIPH] & ~line_d[CI_PERIPH];
    // Mask bits: index 9 is the peripheral line, 0..6 the rest in reverse priority
    for (int i = 0; i < CORE_COUNT; i++) begin
      enab[i] = (i == CI_PERIPH) ? cmask[MASK_PERIPH_BIT] : cmask[CORE_COUNT - 1 - i];
    end
  end

  always_comb begin
    wr_go  = aw_got && w_got && !bv;
    rd_go  = s_axi_arvalid && !rv;
    vec_rd = rd_go && wr_hit(s_axi_araddr, OFF_VECTOR);
    fc_clear = '0;
    fc_force = '0;
    if (wr_go && wr_hit(aw_a, OFF_FORCE_CLEAR)) begin
      fc_clear = w_d[CORE_COUNT-1:0];
      fc_force = w_d[FC_FORCE_LSB +: CORE_COUNT];
    end
    cand_masked = pend & enab;
    cand = (busy && !sens[SENS_NEST_BIT]) ? '0 : cand_masked;
    sel = '0;
    for (int i = CORE_COUNT - 1; i >= 0; i--) begin
      if (cand[i]) sel = 3'(i);
    end
    taken = |cand;
  end

  always_comb begin
    next_line_d = lines;
    next_pend   = (pend & ~fc_clear) | fc_force | trig;
    next_pend[CI_SOFT1] = (pend[CI_SOFT1] & ~fc_clear[CI_SOFT1]) | fc_force[CI_SOFT1];
    next_pend[CI_SOFT0] = (pend[CI_SOFT0] & ~fc_clear[CI_SOFT0]) | fc_force[CI_SOFT0];
    next_vec  = vec;
    next_busy = busy;
    next_stat = stat;
    if (taken) begin
      // A fresh event in the take cycle stays pending
      next_pend[sel] = trig[sel] | fc_force[sel];
      next_vec       = core_slot(sel);
      next_busy      = 1'b1;
      next_stat[EV_TAKEN] = 1'b1;
    end
    if (vec_rd) next_stat[EV_VECTOR] = 1'b1;
    if (wr_go && wr_hit(aw_a, OFF_DONE) && w_d[0]) next_busy = 1'b0;
    if (wr_go && wr_hit(aw_a, OFF_STATUS)) begin
      next_stat = next_stat & ~(w_d[STATUS_W-1:0] & ~stat);
      next_stat = (stat & ~w_d[STATUS_W-1:0]) | (next_stat & ~stat);
      if (taken) next_stat[EV_TAKEN] = 1'b1;
      if (vec_rd) next_stat[EV_VECTOR] = 1'b1;
    end
    next_cmask = (wr_go && wr_hit(aw_a, OFF_CORE_MASK)) ? w_d[CORE_MASK_W-1:0] : cmask;
    next_sens  = (wr_go && wr_hit(aw_a, OFF_SENS)) ? w_d[SENS_W-1:0] : sens;
    next_core_interrupt_mask = (wr_go && wr_hit(aw_a, OFF_IRQ_MASK)) ? w_d[STATUS_W-1:0] : core_interrupt_mask;
  end

  always_comb begin
    next_aw_got = aw_got;
    next_aw_a   = aw_a;
    next_w_got  = w_got;
    next_w_d    = w_d;
    next_bv     = bv;
    next_br     = br;
    if (s_axi_awvalid && !aw_got) begin
      next_aw_got = 1'b1;
      next_aw_a   = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got) begin
      next_w_got = 1'b1;
      next_w_d   = s_axi_wdata;
    end
    if (wr_go) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bv     = 1'b1;
      next_br     = (aw_a > OFF_DONE || aw_a[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
    end
    if (bv && s_axi_bready) next_bv = 1'b0;
    next_rv = rv;
    next_rr = rr;
    next_rd = rd;
    if (rd_go) begin
      next_rv = 1'b1;
      next_rr = RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_CORE_MASK:   next_rd = 32'(cmask);
        OFF_FORCE_CLEAR: next_rd = 32'h0000_0000;
        OFF_SENS:        next_rd = 32'(sens);
        OFF_PERIPH_MASK: next_rd = 32'(link.peripheral_interrupt_mask);
        OFF_PENDING:     next_rd = 32'(pend);
        OFF_VECTOR:      next_rd = 32'(link.vector_value);
        OFF_STATUS:      next_rd = 32'(stat);
        OFF_IRQ_MASK:    next_rd = 32'(core_interrupt_mask);
        OFF_SERVICE:     next_rd = {15'h0000, busy, vec};
        OFF_DONE:        next_rd = 32'h0000_0000;
        default: begin
          next_rd = 32'h0000_0000;
          next_rr = RESP_SLVERR;
        end
      endcase
    end
    if (rv && s_axi_rready) next_rv = 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmask <= '0;
      sens <= '0;
      pend <= '0;
      line_d <= '0;
      vec <= TABLE_FIRST;
      busy <= 1'b0;
      stat <= '0;
      core_interrupt_mask <= '0;
      aw_got <= 1'b0;
      aw_a <= '0;
      w_got <= 1'b0;
      w_d <= '0;
      bv <= 1'b0;
      br <= RESP_OKAY;
      rv <= 1'b0;
      rr <= RESP_OKAY;
      rd <= '0;
    end else begin
      cmask <= next_cmask;
      sens <= next_sens;
      pend <= next_pend;
      line_d <= next_line_d;
      vec <= next_vec;
      busy <= next_busy;
      stat <= next_stat;
      core_interrupt_mask <= next_core_interrupt_mask;
      aw_got <= next_aw_got;
      aw_a <= next_aw_a;
      w_got <= next_w_got;
      w_d <= next_w_d;
      bv <= next_bv;
      br <= next_br;
      rv <= next_rv;
      rr <= next_rr;
      rd <= next_rd;
    end
  end

  assign s_axi_awready = !aw_got;
  assign s_axi_wready  = !w_got;
  assign s_axi_bvalid  = bv;
  assign s_axi_bresp   = br;
  assign s_axi_arready = !rv;
  assign s_axi_rvalid  = rv;
  assign s_axi_rresp   = rr;
  assign s_axi_rdata   = rd;
  assign irq_o         = |(stat & core_interrupt_mask);
  assign link.vector_read = vec_rd;
  assign link.mask_write  = wr_go && wr_hit(aw_a, OFF_PERIPH_MASK);
  assign link.mask_value  = w_d[PERIPH_COUNT-1:0];
endmodule : core_interrupt_logic

// *** verif/pic_link_properties.sv ***
// Concurrent checks on the link between the interrupt controller and the core logic
`timescale 1ns/1ps
module pic_link_properties
  import pic_pkg::*;
(
  input wire logic                    sys_clk_i,
  input wire logic                    rst_i,
  input wire logic                    peripheral_request_line,
  input wire logic [VEC_W-1:0]        vector_value,
  input wire logic                    vector_read,
  input wire logic [PERIPH_COUNT-1:0] peripheral_interrupt_mask,
  input wire logic                    mask_write,
  input wire logic [PERIPH_COUNT-1:0] mask_value
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [4:0] slot_idx;
  // Source index from slot address, meaningful only while a request stands
  assign slot_idx = vector_value[6:2] - 5'h0C;
  a_vec_held: assert property (
    peripheral_request_line && !vector_read |=> $stable(vector_value))
    else $error("vector changed before it was read");
  a_req_stands: assert property (
    peripheral_request_line && !vector_read |=> peripheral_request_line)
    else $error("request dropped without a vector read");
  a_req_gap: assert property (
    peripheral_request_line && vector_read |=> !peripheral_request_line)
    else $error("request not withdrawn after vector read");
  a_vec_range: assert property (
    peripheral_request_line |-> vector_value >= PERIPH_VEC_LO && vector_value <= PERIPH_VEC_HI)
    else $error("vector outside peripheral slots");
  a_vec_slot: assert property (
    peripheral_request_line |-> vector_value[1:0] == 2'b00)
    else $error("vector not on a slot boundary");
  a_req_unmasked: assert property (
    $rose(peripheral_request_line) |-> peripheral_interrupt_mask[slot_idx[3:0]])
    else $error("request raised for a masked source");
  a_mask_load: assert property (
    mask_write |=> peripheral_interrupt_mask == $past(mask_value))
    else $error("mask write not applied");
  a_mask_keep: assert property (
    !mask_write |=> $stable(peripheral_interrupt_mask))
    else $error("mask changed without a write");
  c_req_rise: cover property ($rose(peripheral_request_line));
  c_req_ack: cover property (peripheral_request_line && vector_read);
  c_mask_wr: cover property (mask_write);
endmodule : pic_link_properties

// *** verif/tb.sv ***
// Testbench joining both interrupt ends, driven over AXI4-Lite and event pulses
`timescale 1ns/1ps
module tb;
  import pic_pkg::*;
  logic                    sys_clk_i, rst_i, irq, ext_req;
  logic [PERIPH_COUNT-1:0] periph_event, pending;
  logic [7:0]              awaddr, araddr;
  logic [31:0]             wdata, rdata, rd;
  logic [3:0]              wstrb;
  logic [1:0]              bresp, rresp, rsp;
  logic                    awvalid, awready, wvalid, wready, bvalid, bready;
  logic                    arvalid, arready, rvalid, rready;
  int                      err_count, check_count;

  pic_link_if link_if_i ();
  peripheral_interrupt_controller peripheral_interrupt_controller_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .periph_event_i(periph_event),
    .pending_o(pending), .link(link_if_i));
  core_interrupt_logic core_interrupt_logic_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sport0_tx_i(1'b0), .sport0_rx_i(1'b0),
    .sport1_tx_req_one_i(ext_req), .sport1_rx_req_zero_i(ext_req), .timer_i(1'b0),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_o(irq), .link(link_if_i));
  pic_link_properties pic_link_properties_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .peripheral_request_line(link_if_i.peripheral_request_line),
    .vector_value(link_if_i.vector_value), .vector_read(link_if_i.vector_read),
    .peripheral_interrupt_mask(link_if_i.peripheral_interrupt_mask),
    .mask_write(link_if_i.mask_write), .mask_value(link_if_i.mask_value));

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  // Both channels offered together; each released at the edge its ready is seen
  task axi_write(input logic [7:0] a, input logic [31:0] d);
    logic done;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge sys_clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      // Answer channels stay ready between calls
      if (bvalid === 1'b1) begin
        rsp = bresp;
        done = 1'b1;
      end
    end
  endtask : axi_write

  task axi_read(input logic [7:0] a);
    logic done;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge sys_clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rd = rdata;
        rsp = rresp;
        done = 1'b1;
      end
    end
  endtask : axi_read

  task pulse(input logic [PERIPH_COUNT-1:0] m);
    periph_event <= m;
    @(posedge sys_clk_i);
    periph_event <= '0;
    @(posedge sys_clk_i);
  endtask : pulse

  // Waits for the request, then reads the vector, which also acknowledges it
  task read_vec(input logic [15:0] exp);
    int n;
    n = 0;
    while (link_if_i.peripheral_request_line !== 1'b1 && n < 40) begin
      @(posedge sys_clk_i);
      n++;
    end
    check("request", 32'(link_if_i.peripheral_request_line), 32'h0000_0001);
    axi_read(OFF_VECTOR);
    check("vector", rd, 32'(exp));
  endtask : read_vec

  task test_regs();
    axi_read(OFF_CORE_MASK);
    check("core mask reset", rd, 32'h0000_0000);
    axi_write(OFF_SENS, 32'h0000_0017);
    check("write resp", 32'(rsp), 32'(RESP_OKAY));
    axi_read(OFF_SENS);
    check("sensitivity", rd, 32'h0000_0017);
    axi_write(OFF_SENS, 32'h0000_0000);
    axi_read(8'h40);
    check("unmapped read", 32'(rsp), 32'(RESP_SLVERR));
    $display("test regs done");
  endtask : test_regs

  task test_priority();
    axi_write(OFF_PERIPH_MASK, 32'h0000_07FF);
    pulse(11'h409);
    repeat (4) @(posedge sys_clk_i);
    axi_read(OFF_STATUS);
    check("taken while masked", 32'(rd[EV_TAKEN]), 32'h0000_0000);
    axi_write(OFF_CORE_MASK, 32'h0000_0200);
    repeat (4) @(posedge sys_clk_i);
    axi_read(OFF_SERVICE);
    check("peripheral slot", 32'(rd[15:0]), 32'(VEC_PERIPH));
    axi_write(OFF_CORE_MASK, 32'h0000_0000);
    read_vec(16'h0030);
    read_vec(16'h003C);
    read_vec(16'h0058);
    repeat (2) @(posedge sys_clk_i);
    check("pending drained", 32'(pending), 32'h0000_0000);
    axi_read(OFF_STATUS);
    check("vector read seen", 32'(rd[EV_VECTOR]), 32'h0000_0001);
    axi_write(OFF_DONE, 32'h0000_0001);
    axi_read(OFF_SERVICE);
    check("service ended", 32'(rd[16]), 32'h0000_0000);
    axi_write(OFF_STATUS, 32'h0000_0003);
    $display("test priority done");
  endtask : test_priority

  task test_hold();
    pulse(11'h400);
    repeat (3) @(posedge sys_clk_i);
    pulse(11'h001);
    repeat (3) @(posedge sys_clk_i);
    check("vector held", 32'(link_if_i.vector_value), 32'h0000_0058);
    read_vec(16'h0058);
    read_vec(16'h0030);
    for (int i = 0; i < PERIPH_COUNT; i++) begin
      pulse(11'(1 << i));
      read_vec(16'h0030 + 16'(4 * i));
    end
    $display("test hold done");
  endtask : test_hold

  task test_mask();
    axi_write(OFF_PERIPH_MASK, 32'h0000_07DF);
    pulse(11'h020);
    repeat (4) @(posedge sys_clk_i);
    check("masked request", 32'(link_if_i.peripheral_request_line), 32'h0000_0000);
    axi_read(OFF_PERIPH_MASK);
    check("peripheral mask", rd, 32'h0000_07DF);
    axi_write(OFF_PERIPH_MASK, 32'h0000_07FF);
    read_vec(16'h0044);
    $display("test mask done");
  endtask : test_mask

  task test_soft();
    axi_write(OFF_FORCE_CLEAR, 32'h0000_0800);
    axi_read(OFF_PENDING);
    check("soft forced", 32'(rd[CI_SOFT1]), 32'h0000_0001);
    axi_write(OFF_FORCE_CLEAR, 32'h0000_0008);
    axi_read(OFF_PENDING);
    check("soft cleared", 32'(rd[CI_SOFT1]), 32'h0000_0000);
    axi_write(OFF_CORE_MASK, 32'h0000_0010);
    axi_write(OFF_FORCE_CLEAR, 32'h0000_0800);
    repeat (4) @(posedge sys_clk_i);
    axi_read(OFF_SERVICE);
    check("soft slot", 32'(rd[15:0]), 32'h0000_0018);
    check("irq masked", 32'(irq), 32'h0000_0000);
    axi_write(OFF_IRQ_MASK, 32'h0000_0001);
    check("irq raised", 32'(irq), 32'h0000_0001);
    axi_write(OFF_STATUS, 32'h0000_0001);
    check("irq cleared", 32'(irq), 32'h0000_0000);
    axi_write(OFF_DONE, 32'h0000_0001);
    $display("test soft done");
  endtask : test_soft

  // Both external request lines driven together; their core masks stay off
  task test_sens();
    axi_write(OFF_SENS, 32'h0000_0003);
    ext_req <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    axi_read(OFF_PENDING);
    check("edge caught", 32'(rd[CI_REQ_ZERO:CI_REQ_ONE]), 32'h0000_0003);
    axi_write(OFF_FORCE_CLEAR, 32'h0000_0060);
    axi_read(OFF_PENDING);
    check("edge cleared", 32'(rd[CI_REQ_ZERO:CI_REQ_ONE]), 32'h0000_0000);
    axi_write(OFF_SENS, 32'h0000_0000);
    axi_read(OFF_PENDING);
    check("level pending", 32'(rd[CI_REQ_ZERO:CI_REQ_ONE]), 32'h0000_0003);
    ext_req <= 1'b0;
    axi_write(OFF_FORCE_CLEAR, 32'h0000_0060);
    axi_read(OFF_PENDING);
    check("level cleared", 32'(rd[CI_REQ_ZERO:CI_REQ_ONE]), 32'h0000_0000);
    $display("test sens done");
  endtask : test_sens

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    rst_i = 1'b1;
    {periph_event, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    ext_req = 1'b0;
    wstrb = 4'hF;
    err_count = 0;
    check_count = 0;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    test_regs();
    test_priority();
    test_hold();
    test_mask();
    test_soft();
    test_sens();
    end_sim();
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    end_sim();
  end
endmodule : tb
